// ### hdl/sdr_cmd_pkg.sv
// shared constants, command set and pin encodings of the sdram command layer
package sdr_cmd_pkg;

  // bus widths
  localparam int DATA_W = 32;
  localparam int MASK_W = DATA_W / 8;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int COL_W  = 11;
  localparam int CFG_W  = 2;
  localparam int PIN_W  = 3;

  // field positions
  localparam int AP_BIT = 10;

  // {ras_n, cas_n, we_n} encodings
  localparam logic [PIN_W-1:0] ENC_NOP   = 3'h7;
  localparam logic [PIN_W-1:0] ENC_CLOSE = 3'h2;
  localparam logic [PIN_W-1:0] ENC_OPEN  = 3'h3;
  localparam logic [PIN_W-1:0] ENC_READ  = 3'h5;
  localparam logic [PIN_W-1:0] ENC_WRITE = 3'h4;
  localparam logic [PIN_W-1:0] ENC_STOP  = 3'h6;
  localparam logic [PIN_W-1:0] ENC_MODE  = 3'h0;
  localparam logic [PIN_W-1:0] ENC_RENEW = 3'h1;

  // column width codes: 8, 9, 10, 11 bits
  localparam logic [CFG_W-1:0] COL_BITS_8  = 2'h0;
  localparam logic [CFG_W-1:0] COL_BITS_9  = 2'h1;
  localparam logic [CFG_W-1:0] COL_BITS_10 = 2'h2;
  // bank count codes: 1, 2, 4 banks
  localparam logic [CFG_W-1:0] BANKS_1 = 2'h0;
  localparam logic [CFG_W-1:0] BANKS_2 = 2'h1;

  // reset values
  localparam logic              RST_CKE  = 1'b1;
  localparam logic              RST_CS_N = 1'b0;
  localparam logic [MASK_W-1:0] MASK_ALL = 4'hF;

  // requester command set
  typedef enum logic [3:0] {
    nop_cmd, bank_close_cmd, row_open_cmd, read_cmd, write_burst_cmd,
    write_beat_cmd, read_beat_cmd, burst_stop_cmd, mode_load_cmd,
    self_addressed_renew_cmd, self_timed_hold_cmd, hold_exit_cmd
  } op_t;

  // command to strobe pattern
  function automatic logic [PIN_W-1:0] enc_pins(input op_t op);
    case (op)
      bank_close_cmd:           return ENC_CLOSE;
      row_open_cmd:             return ENC_OPEN;
      read_cmd:                 return ENC_READ;
      write_burst_cmd:          return ENC_WRITE;
      burst_stop_cmd:           return ENC_STOP;
      mode_load_cmd:            return ENC_MODE;
      self_addressed_renew_cmd: return ENC_RENEW;
      self_timed_hold_cmd:      return ENC_RENEW;
      default:                  return ENC_NOP;
    endcase
  endfunction

  // column trimmed to width, high bit placed above the precharge bit
  function automatic logic [ADDR_W-1:0] col_addr(input logic [COL_W-1:0] col,
                                                 input logic [CFG_W-1:0] code);
    logic [COL_W-1:0] m;
    case (code)
      COL_BITS_8:  m = 11'h0FF;
      COL_BITS_9:  m = 11'h1FF;
      COL_BITS_10: m = 11'h3FF;
      default:     m = 11'h7FF;
    endcase
    m = m & col;
    return {1'b0, m[10], 1'b0, m[9:0]};
  endfunction

  // bank trimmed to the fitted bank count
  function automatic logic [BANK_W-1:0] bank_trim(input logic [BANK_W-1:0] ba,
                                                  input logic [CFG_W-1:0] code);
    case (code)
      BANKS_1: return 2'h0;
      BANKS_2: return ba & 2'h1;
      default: return ba;
    endcase
  endfunction

endpackage

// ### hdl/sdr_pin_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sdr_pin_sync #(
  parameter int W = 32
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (clk_en_i) begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// ### hdl/sdr_clk_div.sv
// divide-by-two sdram clock and command update strobe
`timescale 1ns/1ps
module sdr_clk_div (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic clk_en_i,
  output logic      sclk_o,
  output logic      upd_o
);

  logic sclk_r;

  // toggle each enabled cycle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_r <= 1'b0;
    end else if (clk_en_i) begin
      sclk_r <= ~sclk_r;
    end
  end

  // pins update as the clock falls, half a period ahead of its rise
  assign sclk_o = sclk_r;
  assign upd_o  = sclk_r & clk_en_i;

endmodule

// ### hdl/sdr_sdram_command_interface.sv
// sdram command and pin layer: encodes requests onto the sdram pins
`timescale 1ns/1ps

// Operation
// - chip select is held low at all times, idle included.
// - bank close: ras low, we low; addr bit 10 selects all banks.
// - row open: ras low; bank and full row on address lines.
// - read: cas low, we high; bank and start column out.
// - write burst: cas low, we low; bank and start column out.
// - read and write always drive addr bit 10 low.
// - burst stop: we low only; bank and address don't care.
// - mode load only while the init phase input is high.
// - auto refresh: ras and cas low, we high, cke high.
// - self refresh: cke low with ras and cas low, we high.
// - every cycle without another command carries the nop pattern.
// - one mask output per byte lane gates each data byte.
// - two-bit bank output selects the bank of bank commands.
// - address carries row on row open, column on read and write.
// - column width 8 to 11 bits, one two or four banks.
module sdr_sdram_command_interface (
  input  wire logic                             ref_clk_i,
  input  wire logic                             rst_b_i,
  input  wire logic                             clk_en_i,
  input  wire logic                             cmd_valid_i,
  input  wire sdr_cmd_pkg::op_t                 cmd_op_i,
  input  wire logic [sdr_cmd_pkg::BANK_W-1:0]   cmd_bank_i,
  input  wire logic [sdr_cmd_pkg::ADDR_W-1:0]   cmd_addr_i,
  input  wire logic                             cmd_all_banks_i,
  input  wire logic [sdr_cmd_pkg::DATA_W-1:0]   wr_data_i,
  input  wire logic [sdr_cmd_pkg::MASK_W-1:0]   lane_mask_i,
  input  wire logic                             init_phase_i,
  input  wire logic [sdr_cmd_pkg::CFG_W-1:0]    col_bits_i,
  input  wire logic [sdr_cmd_pkg::CFG_W-1:0]    bank_count_i,
  input  wire logic [sdr_cmd_pkg::DATA_W-1:0]   mem_data_io_i,
  output logic                                  cmd_ready_o,
  output logic                                  cmd_refused_o,
  output logic [sdr_cmd_pkg::DATA_W-1:0]        rd_data_o,
  output logic                                  rd_valid_o,
  output logic                                  in_hold_o,
  output logic                                  mem_clock_out_o,
  output logic                                  mem_clock_enable_out_o,
  output logic                                  mem_chip_select_n_o,
  output logic                                  mem_row_strobe_n_o,
  output logic                                  mem_col_strobe_n_o,
  output logic                                  mem_write_strobe_n_o,
  output logic [sdr_cmd_pkg::BANK_W-1:0]        mem_bank_sel_out_o,
  output logic [sdr_cmd_pkg::ADDR_W-1:0]        mem_addr_out_o,
  output logic [sdr_cmd_pkg::MASK_W-1:0]        byte_lane_mask_out_o,
  output logic [sdr_cmd_pkg::DATA_W-1:0]        mem_data_io_o,
  output logic                                  mem_data_io_oe_o
);
  import sdr_cmd_pkg::*;

  typedef enum logic {st_active, st_hold} state_t;

  logic              sclk;
  logic              upd;
  logic [DATA_W-1:0] dq_sync;
  state_t            state_r;
  state_t            state_nxt;
  logic              ready_r;
  logic              refused_r;
  logic [DATA_W-1:0] rd_data_r;
  logic              rd_valid_r;
  logic              cke_r;
  logic              cs_n_r;
  logic [PIN_W-1:0]  pins_r;
  logic [BANK_W-1:0] ba_r;
  logic [ADDR_W-1:0] addr_r;
  logic [MASK_W-1:0] dqm_r;
  logic [DATA_W-1:0] dq_out_r;
  logic              dq_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // clock divider and read data synchroniser

  sdr_clk_div u_clk_div (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .clk_en_i  (clk_en_i),
    .sclk_o    (sclk),
    .upd_o     (upd)
  );

  sdr_pin_sync #(.W(DATA_W)) u_dq_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .clk_en_i  (clk_en_i),
    .async_i   (mem_data_io_i),
    .sync_o    (dq_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request acceptance and refusal

  wire in_hold  = (state_r == st_hold);
  wire taken    = upd & cmd_valid_i;
  wire is_mode  = (cmd_op_i == mode_load_cmd);
  wire is_exit  = (cmd_op_i == hold_exit_cmd);
  wire hold_ok  = is_exit | (cmd_op_i == nop_cmd);
  wire bad_mode = is_mode & ~init_phase_i;
  // in hold only exit or nop are legal; exit only in hold
  wire refuse   = taken & (bad_mode | (in_hold & ~hold_ok) | (~in_hold & is_exit));
  wire go       = taken & ~refuse;
  // anything not issued becomes a nop
  wire op_t op_eff = go ? cmd_op_i : nop_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // pin value decode

  wire is_rw    = (op_eff == read_cmd) | (op_eff == write_burst_cmd);
  wire is_open  = (op_eff == row_open_cmd);
  wire is_close = (op_eff == bank_close_cmd);
  wire is_hold  = (op_eff == self_timed_hold_cmd);
  wire is_wdata = (op_eff == write_burst_cmd) | (op_eff == write_beat_cmd);
  wire is_lane  = is_rw | (op_eff == write_beat_cmd) | (op_eff == read_beat_cmd);

  wire [BANK_W-1:0] bank_t  = bank_trim(cmd_bank_i, bank_count_i);
  // column form keeps bit 10 low
  wire [ADDR_W-1:0] col_a   = col_addr(cmd_addr_i[COL_W-1:0], col_bits_i);
  // only bit 10 used by bank close
  wire [ADDR_W-1:0] close_a = 13'(cmd_all_banks_i) << AP_BIT;

  // cke drops on hold entry, rises on exit
  wire cke_nxt = in_hold ? (op_eff == hold_exit_cmd) : ~is_hold;
  wire [PIN_W-1:0] pins_nxt = enc_pins(op_eff);
  wire [BANK_W-1:0] ba_nxt =
    (is_rw | is_open | (is_close & ~cmd_all_banks_i)) ? bank_t : 2'h0;
  // row on open, column on read and write
  wire [ADDR_W-1:0] addr_nxt =
    is_open                   ? cmd_addr_i :
    is_rw                     ? col_a      :
    is_close                  ? close_a    :
    (op_eff == mode_load_cmd) ? cmd_addr_i : '0;
  // lane mask on data cycles, all lanes masked elsewhere
  wire [MASK_W-1:0] dqm_nxt = is_lane ? lane_mask_i : MASK_ALL;

  ////////////////////////////////////////////////////////////////////////////
  // hold state

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_active: if (is_hold) state_nxt = st_hold;
      st_hold:   if (op_eff == hold_exit_cmd) state_nxt = st_active;
      default:   state_nxt = st_active;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= st_active;
    end else if (upd) begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sdram pin registers

  // pins load only on the falling sdram clock edge
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cke_r    <= RST_CKE;
      pins_r   <= ENC_NOP;
      ba_r     <= '0;
      addr_r   <= '0;
      dqm_r    <= MASK_ALL;
      dq_out_r <= '0;
      dq_oe_r  <= 1'b0;
    end else if (upd) begin
      cke_r    <= cke_nxt;
      pins_r   <= pins_nxt;
      ba_r     <= ba_nxt;
      addr_r   <= addr_nxt;
      dqm_r    <= dqm_nxt;
      dq_out_r <= is_wdata ? wr_data_i : dq_out_r;
      dq_oe_r  <= is_wdata;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_n_r <= RST_CS_N;
    end else if (clk_en_i) begin
      cs_n_r <= RST_CS_N;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // requester side handshake and read capture

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_r    <= 1'b0;
      refused_r  <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
    end else if (clk_en_i) begin
      ready_r    <= ~sclk; // high in the cycle before each update edge
      refused_r  <= refuse;
      rd_valid_r <= upd & ~dq_oe_r;
      rd_data_r  <= (upd & ~dq_oe_r) ? dq_sync : rd_data_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign cmd_ready_o            = ready_r;
  assign cmd_refused_o          = refused_r;
  assign rd_data_o              = rd_data_r;
  assign rd_valid_o             = rd_valid_r;
  assign in_hold_o              = (state_r == st_hold);
  assign mem_clock_out_o        = sclk;
  assign mem_clock_enable_out_o = cke_r;
  assign mem_chip_select_n_o    = cs_n_r;
  assign mem_row_strobe_n_o     = pins_r[2];
  assign mem_col_strobe_n_o     = pins_r[1];
  assign mem_write_strobe_n_o   = pins_r[0];
  assign mem_bank_sel_out_o     = ba_r;
  assign mem_addr_out_o         = addr_r;
  assign byte_lane_mask_out_o   = dqm_r;
  assign mem_data_io_o          = dq_out_r;
  assign mem_data_io_oe_o       = dq_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  wire [PIN_W-1:0] pins_o = {mem_row_strobe_n_o, mem_col_strobe_n_o, mem_write_strobe_n_o};

  a_cs_held: assert property (mem_chip_select_n_o == 1'b0)
    else $error("chip select left its asserted level");

  a_close_enc: assert property (
    go && cmd_op_i == bank_close_cmd |=> pins_o == ENC_CLOSE
      && mem_clock_enable_out_o && mem_addr_out_o[AP_BIT] == $past(cmd_all_banks_i))
    else $error("bank close pattern or bit 10 wrong");

  a_open_row: assert property (
    go && cmd_op_i == row_open_cmd |=> pins_o == ENC_OPEN
      && mem_addr_out_o == $past(cmd_addr_i)
      && mem_bank_sel_out_o == bank_trim($past(cmd_bank_i), $past(bank_count_i)))
    else $error("row open pattern, row or bank wrong");

  a_read_enc: assert property (
    go && cmd_op_i == read_cmd |=> pins_o == ENC_READ && mem_clock_enable_out_o
      && mem_addr_out_o == col_addr($past(cmd_addr_i[COL_W-1:0]), $past(col_bits_i))
      && !mem_data_io_oe_o)
    else $error("read pattern or column wrong");

  a_write_enc: assert property (
    go && cmd_op_i == write_burst_cmd |=> pins_o == ENC_WRITE
      && mem_data_io_oe_o && mem_data_io_o == $past(wr_data_i)
      && byte_lane_mask_out_o == $past(lane_mask_i))
    else $error("write pattern, data or mask wrong");

  a_no_autopre: assert property (
    (pins_o == ENC_READ || pins_o == ENC_WRITE) |-> !mem_addr_out_o[AP_BIT])
    else $error("auto precharge bit set on column command");

  a_stop_enc: assert property (
    go && cmd_op_i == burst_stop_cmd |=> pins_o == ENC_STOP ##1 pins_o == ENC_STOP)
    else $error("burst stop pattern wrong or short");

  a_mode_guard: assert property (
    taken && is_mode && !init_phase_i |=> cmd_refused_o && pins_o == ENC_NOP)
    else $error("mode load issued outside init");

  a_renew_enc: assert property (
    go && cmd_op_i == self_addressed_renew_cmd |=> pins_o == ENC_RENEW
      && mem_clock_enable_out_o)
    else $error("auto refresh pattern wrong");

  a_hold_entry: assert property (
    go && cmd_op_i == self_timed_hold_cmd |=> !mem_clock_enable_out_o
      && pins_o == ENC_RENEW && in_hold_o)
    else $error("self refresh entry wrong");

  a_hold_keep: assert property (
    in_hold_o && !(go && is_exit) |=> !mem_clock_enable_out_o)
    else $error("cke rose without exit");

  a_idle_nop: assert property (
    upd && !cmd_valid_i |=> pins_o == ENC_NOP)
    else $error("idle cycle not a nop");

  a_col_width: assert property (
    go && cmd_op_i == read_cmd && col_bits_i == COL_BITS_8
      |=> mem_addr_out_o[ADDR_W-1:8] == '0)
    else $error("column not trimmed to 8 bits");

  a_pins_stable: assert property (
    !$past(upd) |-> $stable({pins_o, mem_addr_out_o, mem_bank_sel_out_o,
      byte_lane_mask_out_o, mem_clock_enable_out_o}))
    else $error("pins changed off the update edge");

  a_bus_release: assert property (
    mem_data_io_oe_o |-> pins_o == ENC_WRITE || pins_o == ENC_NOP)
    else $error("data bus driven outside write");

  c_write: cover property (go && cmd_op_i == write_burst_cmd ##2 go && is_wdata);
  c_read:  cover property (go && cmd_op_i == read_cmd ##1 rd_valid_o);
  c_hold:  cover property (in_hold_o ##[1:40] go && is_exit);
  c_ref:   cover property (cmd_refused_o);

endmodule

// ### testbench/sdr_mem_model.sv
// behavioural sdram partner: answers read commands on the data pins
`timescale 1ns/1ps
module sdr_mem_model (
  input  wire logic        sclk_i,
  input  wire logic        cke_i,
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic [12:0] addr_i,
  output logic      [31:0] dq_o
);
  logic [1:0] left_r;
  logic       rd_hit;

  ////////////////////////////////////////////////////////////////
  // read pattern decode
  assign rd_hit = cke_i && !cs_n_i && ({ras_n_i, cas_n_i, we_n_i} == 3'h5);

  initial begin
    dq_o   = 32'h5555AAAA;
    left_r = 2'h0;
  end

  // word held two sdram cycles, then the released bus toggles every cycle
  always @(posedge sclk_i) begin
    if (rd_hit) begin
      dq_o   <= 32'hC0DE0000 | {19'h0, addr_i};
      left_r <= 2'h2;
    end else begin
      dq_o   <= (left_r == 2'h2) ? dq_o : ~dq_o;
      left_r <= (left_r != 2'h0) ? left_r - 2'h1 : 2'h0;
    end
  end
endmodule

// ### testbench/sdr_sdram_command_interface_tb.sv
// self-checking bench for the sdram command and pin layer
`timescale 1ns/1ps
module sdr_sdram_command_interface_tb;
  import sdr_cmd_pkg::*;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              en = 1'b1;
  logic              valid = 1'b0;
  op_t               op = nop_cmd;
  logic [BANK_W-1:0] bank = 2'h0;
  logic [ADDR_W-1:0] addr = 13'h0000;
  logic              all_b = 1'b0;
  logic [DATA_W-1:0] wdata = 32'h00000000;
  logic [MASK_W-1:0] lmask = 4'h0;
  logic              init = 1'b0;
  logic [CFG_W-1:0]  colc = 2'h3;
  logic [CFG_W-1:0]  bankc = 2'h2;
  wire  [DATA_W-1:0] dq_bus, model_dq, rd_data, dout;
  wire  [BANK_W-1:0] ba;
  wire  [ADDR_W-1:0] a;
  wire  [MASK_W-1:0] dqm;
  wire               ready, refused, rd_valid, hold, sclk, cke, cs_n, ras_n, cas_n, we_n, oe;
  int                bad_count = 0;
  int                num_checks = 0;
  int                cycles = 0;

  ////////////////////////////////////////////////////////////////
  // clock, bus resolution, instances
  initial begin
    forever #2.5 clk = ~clk;
  end
  assign dq_bus = oe ? dout : model_dq;

  sdr_sdram_command_interface u_sdr_sdram_command_interface (
    .ref_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en), .cmd_valid_i(valid),
    .cmd_op_i(op), .cmd_bank_i(bank), .cmd_addr_i(addr), .cmd_all_banks_i(all_b),
    .wr_data_i(wdata), .lane_mask_i(lmask), .init_phase_i(init), .col_bits_i(colc),
    .bank_count_i(bankc), .mem_data_io_i(dq_bus), .cmd_ready_o(ready),
    .cmd_refused_o(refused), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .in_hold_o(hold), .mem_clock_out_o(sclk), .mem_clock_enable_out_o(cke),
    .mem_chip_select_n_o(cs_n), .mem_row_strobe_n_o(ras_n), .mem_col_strobe_n_o(cas_n),
    .mem_write_strobe_n_o(we_n), .mem_bank_sel_out_o(ba), .mem_addr_out_o(a),
    .byte_lane_mask_out_o(dqm), .mem_data_io_o(dout), .mem_data_io_oe_o(oe)
  );

  sdr_mem_model u_sdr_mem_model (
    .sclk_i(sclk), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
    .we_n_i(we_n), .addr_i(a), .dq_o(model_dq)
  );

  ////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // chip select low plus {cke, ras_n, cas_n, we_n}
  task automatic pins(input logic [3:0] e);
    chk({cs_n, cke, ras_n, cas_n, we_n}, {1'b0, e});
  endtask

  // present at a ready cycle, drop after the taking edge; pins then visible
  task automatic issue(input op_t o, input logic [1:0] b, input logic [12:0] ad,
                       input logic al);
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    op = o; bank = b; addr = ad; all_b = al; valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    op = nop_cmd;
  endtask

  task automatic gap;
    repeat (2) @(negedge clk);
  endtask

  task automatic expect_refused;
    logic r;
    r = refused;
    @(negedge clk);
    r = r | refused;
    chk(r, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_cmds;
    issue(bank_close_cmd, 2'h2, 13'h0400, 1'b0);
    pins({1'b1, ENC_CLOSE}); chk({ba, a[10]}, {2'h2, 1'b0});
    issue(bank_close_cmd, 2'h1, 13'h0000, 1'b1);
    pins({1'b1, ENC_CLOSE}); chk(a[10], 1'b1);
    issue(row_open_cmd, 2'h3, 13'h1ABC, 1'b0);
    pins({1'b1, ENC_OPEN}); chk({ba, a}, {2'h3, 13'h1ABC});
    issue(burst_stop_cmd, 2'h3, 13'h1FFF, 1'b0);
    pins({1'b1, ENC_STOP});
    issue(self_addressed_renew_cmd, 2'h0, 13'h0000, 1'b0);
    pins({1'b1, ENC_RENEW});
    gap;
    pins({1'b1, ENC_NOP}); chk({oe, dqm}, {1'b0, 4'hF});
  endtask

  task automatic t_widths;
    logic [10:0] m;
    lmask = 4'h5;
    for (int i = 0; i < 4; i++) begin
      colc = i[1:0];
      m = 11'h7FF >> (3 - i);
      issue(read_cmd, 2'h3, 13'h07FF, 1'b0);
      pins({1'b1, ENC_READ}); chk(a, {1'b0, m[10], 1'b0, m[9:0]});
      chk({oe, dqm}, {1'b0, 4'h5});
    end
    issue(read_beat_cmd, 2'h0, 13'h0000, 1'b0);
    pins({1'b1, ENC_NOP});
    chk({oe, dqm}, {1'b0, 4'h5});
    for (int j = 0; j < 3; j++) begin
      bankc = j[1:0];
      issue(row_open_cmd, 2'h3, 13'h0001, 1'b0);
      chk(ba, (j == 0) ? 2'h0 : (j == 1) ? 2'h1 : 2'h3);
    end
    colc = 2'h3;
  endtask

  task automatic t_write;
    wdata = 32'hCAFE1234;
    lmask = 4'h6;
    issue(write_burst_cmd, 2'h1, 13'h0523, 1'b0);
    pins({1'b1, ENC_WRITE}); chk({ba, a}, {2'h1, 13'h0923});
    chk({oe, dqm, dout}, {1'b1, 4'h6, 32'hCAFE1234});
    wdata = 32'h0BAD0F0F;
    issue(write_beat_cmd, 2'h1, 13'h0000, 1'b0);
    pins({1'b1, ENC_NOP}); chk({oe, dout}, {1'b1, 32'h0BAD0F0F});
    gap;
    chk({oe, dqm}, {1'b0, 4'hF});
  endtask

  task automatic t_mode;
    init = 1'b0;
    issue(mode_load_cmd, 2'h0, 13'h0033, 1'b0);
    pins({1'b1, ENC_NOP}); expect_refused;
    init = 1'b1;
    issue(mode_load_cmd, 2'h0, 13'h0033, 1'b0);
    pins({1'b1, ENC_MODE}); chk(a, 13'h0033);
    init = 1'b0;
  endtask

  task automatic t_hold;
    issue(self_timed_hold_cmd, 2'h0, 13'h0000, 1'b0);
    pins({1'b0, ENC_RENEW}); chk(hold, 1'b1);
    issue(read_cmd, 2'h0, 13'h0010, 1'b0);
    pins({1'b0, ENC_NOP}); expect_refused;
    issue(hold_exit_cmd, 2'h0, 13'h0000, 1'b0);
    pins({1'b1, ENC_NOP}); chk(hold, 1'b0);
    issue(hold_exit_cmd, 2'h0, 13'h0000, 1'b0);
    pins({1'b1, ENC_NOP}); expect_refused;
  endtask

  // clock enable low freezes the sdram clock, handshake and pins
  task automatic t_freeze;
    issue(row_open_cmd, 2'h1, 13'h0ACE, 1'b0);
    en = 1'b0;
    repeat (5) @(negedge clk);
    chk({sclk, ready, ba, a}, {1'b0, 1'b0, 2'h1, 13'h0ACE});
    pins({1'b1, ENC_OPEN});
    en = 1'b1;
  endtask

  task automatic t_read_data;
    int   n;
    logic seen;
    seen = 1'b0;
    lmask = 4'h0;
    issue(read_cmd, 2'h0, 13'h0055, 1'b0);
    for (n = 0; n < 30 && !seen; n++) begin
      @(negedge clk);
      seen = (rd_valid === 1'b1) && (rd_data === 32'hC0DE0055);
    end
    chk(seen, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////
  // verdict and hang guard
  task automatic report_and_stop;
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    pins({1'b1, ENC_NOP});
    chk({oe, dqm, ready, sclk, hold}, {1'b0, 4'hF, 3'h0});
    rst_b = 1'b1;
    t_cmds();
    t_freeze();
    t_widths();
    t_write();
    t_mode();
    t_hold();
    t_read_data();
    report_and_stop();
  end
endmodule
